// ---- bench/sgcr_regs_tb.sv ----
// Self-checking testbench for the global configuration register slice
`timescale 1ns/100ps
`include "sgcr_cfg.svh"

module sgcr_regs_tb;
  import sgcr_pkg::*;

  // Short periods keep the run small; expectations follow these values
  localparam int unsigned FAST = 20;
  localparam int unsigned SLOW = 50;

  logic        sys_clk        = 1'b0;
  logic        rstn           = 1'b0;
  sgcr_strap_t strap_pins     = 4'b1011;
  logic [7:0]  reg_addr       = 8'h00;
  logic        reg_wr         = 1'b0;
  logic [7:0]  reg_wdata      = 8'h00;
  logic        reg_rd         = 1'b0;
  logic [7:0]  reg_rdata;
  logic [2:0]  port_low_speed = 3'b010;
  logic [2:0]  bcast_block    = 3'b000;
  logic [2:0]  storm_drop;
  sgcr_ctrl_t  ctrl;
  int          error_cnt      = 0;
  int          checks         = 0;
  int          cycles         = 0;

  sgcr_regs #(.FAST_CYC(FAST), .SLOW_CYC(SLOW), .NPORT(3)) i_sgcr_regs (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .strap_pins     (strap_pins),
    .reg_addr       (reg_addr),
    .reg_wr         (reg_wr),
    .reg_wdata      (reg_wdata),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .port_low_speed (port_low_speed),
    .bcast_block    (bcast_block),
    .storm_drop     (storm_drop),
    .ctrl           (ctrl)
  );

  always #25 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // Ceiling well above the expected run of about three hundred and thirty cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_cnt(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cnt

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    chk(what, {8'h00, exp}, {8'h00, reg_rdata});
  endtask : rd

  // Bounded wait for a drop level, sampled mid-cycle
  task automatic wait_lvl(input int p, input logic v, output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (storm_drop[p] !== v && n < 200);
  endtask : wait_lvl

  // Threshold zero drops all but the cycle after each period end
  task automatic period(input int p, input int exp, input string what);
    int n0;
    int n1;
    // Align on a real period end; a fresh write may land mid-period
    wait_lvl(p, 1'b1, n0);
    wait_lvl(p, 1'b0, n0);
    wait_lvl(p, 1'b1, n0);
    wait_lvl(p, 1'b0, n1);
    chk_cnt(what, exp, n0 + n1);
  endtask : period

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    @(negedge sys_clk);
    chk("ctrl_reset", {5'b10011, 11'h063}, ctrl);
    rd(`SGCR_OFS_MII_STORM, 8'h20, "mii_storm_reset");
    rd(`SGCR_OFS_STORM_LO, 8'h63, "storm_lo_reset");
    rd(`SGCR_OFS_TEST_A, 8'h00, "test_a_reset");
    rd(`SGCR_OFS_TEST_B, 8'h24, "test_b_reset");
    rd(`SGCR_OFS_TEST_C, 8'h35, "test_c_reset");
    rd(`SGCR_OFS_LED_CTRL, 8'h8a, "led_reset");
  endtask : t_reset

  task automatic t_rw;
    // Straps moved after reset must not reach the registers
    @(posedge sys_clk);
    strap_pins <= 4'b0100;
    wr(`SGCR_OFS_MII_STORM, 8'h1d);
    wr(`SGCR_OFS_STORM_LO, 8'ha5);
    wr(`SGCR_OFS_LED_CTRL, 8'h0a);
    wr(8'h0c, 8'hff);
    @(negedge sys_clk);
    chk("ctrl_rw", {5'b01101, 11'h5a5}, ctrl);
    rd(`SGCR_OFS_MII_STORM, 8'h1d, "mii_storm_rw");
    rd(`SGCR_OFS_LED_CTRL, 8'h0a, "led_rw");
    rd(8'h0c, 8'h00, "unmapped_rd");
    wr(`SGCR_OFS_MII_STORM, 8'h20);
    @(negedge sys_clk);
    chk("flow_on", 16'h0001, {15'h0000, ctrl.flow_ctrl_en});
  endtask : t_rw

  task automatic t_period;
    wr(`SGCR_OFS_MII_STORM, 8'h10);
    wr(`SGCR_OFS_STORM_LO, 8'h00);
    period(0, FAST, "period_p0_fast");
    period(1, SLOW, "period_p1_slow");
    period(2, SLOW, "period_p3_slow");
    wr(`SGCR_OFS_MII_STORM, 8'h00);
    period(2, FAST, "period_p3_fast");
  endtask : t_period

  task automatic t_drop;
    int n;
    // Raise the threshold while dropping, then align on the period end
    wr(`SGCR_OFS_STORM_LO, 8'h03);
    wait_lvl(0, 1'b0, n);
    @(posedge sys_clk);
    bcast_block <= 3'b001;
    @(posedge sys_clk);
    @(posedge sys_clk);
    bcast_block <= 3'b000;
    @(negedge sys_clk);
    // Only port 0 is judged; the others may still sit in a dropping period
    chk("below_threshold", 16'h0000, {15'h0000, storm_drop[0]});
    @(posedge sys_clk);
    bcast_block <= 3'b001;
    @(posedge sys_clk);
    bcast_block <= 3'b000;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("at_threshold", 16'h0001, {15'h0000, storm_drop[0]});
    // Six cycles of the period are gone; drop must stand to its end
    wait_lvl(0, 1'b0, n);
    chk_cnt("drop_until_end", FAST - 6, n);
  endtask : t_drop

  task automatic t_rerst;
    // Second reset takes the moved straps and drops the written values
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("ctrl_rerst", {5'b01000, 11'h063}, ctrl);
    rd(`SGCR_OFS_MII_STORM, 8'h10, "mii_rerst");
    rd(`SGCR_OFS_LED_CTRL, 8'h08, "led_rerst");
    rd(`SGCR_OFS_STORM_LO, 8'h63, "storm_lo_rerst");
  endtask : t_rerst

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_rw();
    t_period();
    t_drop();
    t_rerst();
    test_done();
  end

endmodule : sgcr_regs_tb

// ---- logic/sgcr_cfg.svh ----
// Constants for the switch global configuration register slice
`ifndef SGCR_CFG_SVH
`define SGCR_CFG_SVH

`define SGCR_ADDR_W          8
`define SGCR_OFS_MII_STORM   8'h06
`define SGCR_OFS_STORM_LO    8'h07
`define SGCR_OFS_TEST_A      8'h08
`define SGCR_OFS_TEST_B      8'h09
`define SGCR_OFS_TEST_C      8'h0a
`define SGCR_OFS_LED_CTRL    8'h0b

`define SGCR_BIT_FLOW        5
`define SGCR_BIT_LOW_SPEED   4
`define SGCR_BIT_NULL_VID    3
`define SGCR_BIT_LED_HI      7
`define SGCR_BIT_LED_RSVD    6
`define SGCR_BIT_LED_LO      1

`define SGCR_RST_MII_STORM   8'h00
`define SGCR_RST_STORM_LO    8'h63
`define SGCR_RST_TEST_A      8'h00
`define SGCR_RST_TEST_B      8'h24
`define SGCR_RST_TEST_C      8'h35
`define SGCR_RST_LED_CTRL    8'h08

`define SGCR_CLK_HZ          20000000
`define SGCR_PERIOD_FAST_MS  67
`define SGCR_PERIOD_SLOW_MS  500
`define SGCR_PERIOD_FAST_CYC (`SGCR_PERIOD_FAST_MS * (`SGCR_CLK_HZ / 1000))
`define SGCR_PERIOD_SLOW_CYC (`SGCR_PERIOD_SLOW_MS * (`SGCR_CLK_HZ / 1000))
`define SGCR_PERIOD_W        24
`define SGCR_NUM_PORTS       3

`endif

// ---- logic/sgcr_pkg.sv ----
// Types shared by the switch global configuration register slice
package sgcr_pkg;

  typedef struct packed {
    logic       flow_ctrl_en;
    logic       port3_mii_low_speed;
    logic       null_vlan_id_substitute;
    logic       led_mode_sel_hi;
    logic       led_mode_sel_lo;
    logic [10:0] storm_threshold;
  } sgcr_ctrl_t;

  typedef struct packed {
    logic       sw_mii_rx_bit3_strap;
    logic       sw_mii_rx_bit1_strap;
    logic       led_mode_sel_hi;
    logic       led_mode_sel_lo;
  } sgcr_strap_t;

  typedef enum logic [1:0] {
    SGCR_ST_BOOT = 2'b01,
    SGCR_ST_RUN  = 2'b10
  } sgcr_state_t;

endpackage : sgcr_pkg

// ---- logic/sgcr_regs.sv ----
// Switch global configuration registers: Port 3 MII, storm, LED, test
`timescale 1ns/100ps
`include "sgcr_cfg.svh"

module sgcr_regs #(
  parameter int unsigned FAST_CYC = `SGCR_PERIOD_FAST_CYC,
  parameter int unsigned SLOW_CYC = `SGCR_PERIOD_SLOW_CYC,
  parameter int unsigned NPORT    = `SGCR_NUM_PORTS
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire sgcr_pkg::sgcr_strap_t   strap_pins,
  input  wire logic [`SGCR_ADDR_W-1:0] reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  input  wire logic [NPORT-1:0]        port_low_speed,
  input  wire logic [NPORT-1:0]        bcast_block,
  output logic [NPORT-1:0]             storm_drop,
  output sgcr_pkg::sgcr_ctrl_t         ctrl
);
  import sgcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Strap pins are asynchronous to sys_clk, two stages before use
  sgcr_strap_t strap_s1_q, strap_s2_q;

  always_ff @(posedge sys_clk) begin
    strap_s1_q <= strap_pins;
    strap_s2_q <= strap_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  sgcr_state_t state_q, state_d;
  logic [7:0]  mii_q, mii_d;
  logic [7:0]  storm_lo_q, storm_lo_d;
  logic [7:0]  test_a_q, test_a_d;
  logic [7:0]  test_b_q, test_b_d;
  logic [7:0]  test_c_q, test_c_d;
  logic [7:0]  led_q, led_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        wr_ok;

  always_comb begin
    state_d    = state_q;
    mii_d      = mii_q;
    storm_lo_d = storm_lo_q;
    test_a_d   = test_a_q;
    test_b_d   = test_b_q;
    test_c_d   = test_c_q;
    led_d      = led_q;
    rdata_d    = rdata_q;
    wr_ok      = 1'b0;
    case (state_q)
      SGCR_ST_BOOT: begin
        // Async reset can only load constants, so straps land here
        mii_d[`SGCR_BIT_FLOW] = strap_s2_q.sw_mii_rx_bit3_strap;
        mii_d[`SGCR_BIT_LOW_SPEED] =
          strap_s2_q.sw_mii_rx_bit1_strap;
        led_d[`SGCR_BIT_LED_HI] = strap_s2_q.led_mode_sel_hi;
        led_d[`SGCR_BIT_LED_LO] = strap_s2_q.led_mode_sel_lo;
        state_d = SGCR_ST_RUN;
      end
      SGCR_ST_RUN: begin
        wr_ok = reg_wr;
      end
      default: begin
        state_d = SGCR_ST_BOOT;
      end
    endcase
    if (wr_ok) begin
      // Plain read/write storage; reserved bits hold whatever is written
      case (reg_addr)
        `SGCR_OFS_MII_STORM: mii_d      = reg_wdata;
        `SGCR_OFS_STORM_LO:  storm_lo_d = reg_wdata;
        `SGCR_OFS_TEST_A:    test_a_d   = reg_wdata;
        `SGCR_OFS_TEST_B:    test_b_d   = reg_wdata;
        `SGCR_OFS_TEST_C:    test_c_d   = reg_wdata;
        `SGCR_OFS_LED_CTRL:  led_d      = reg_wdata;
        default:             ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `SGCR_OFS_MII_STORM: rdata_d = mii_q;
        `SGCR_OFS_STORM_LO:  rdata_d = storm_lo_q;
        `SGCR_OFS_TEST_A:    rdata_d = test_a_q;
        `SGCR_OFS_TEST_B:    rdata_d = test_b_q;
        `SGCR_OFS_TEST_C:    rdata_d = test_c_q;
        `SGCR_OFS_LED_CTRL:  rdata_d = led_q;
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= SGCR_ST_BOOT;
      mii_q      <= `SGCR_RST_MII_STORM;
      storm_lo_q <= `SGCR_RST_STORM_LO;
      test_a_q   <= `SGCR_RST_TEST_A;
      test_b_q   <= `SGCR_RST_TEST_B;
      test_c_q   <= `SGCR_RST_TEST_C;
      led_q      <= `SGCR_RST_LED_CTRL;
      rdata_q    <= 8'h00;
    end else begin
      state_q    <= state_d;
      mii_q      <= mii_d;
      storm_lo_q <= storm_lo_d;
      test_a_q   <= test_a_d;
      test_b_q   <= test_b_d;
      test_c_q   <= test_c_d;
      led_q      <= led_d;
      rdata_q    <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs are bare register bits, no logic after the flops
  always_comb begin
    ctrl.flow_ctrl_en            = mii_q[`SGCR_BIT_FLOW];
    ctrl.port3_mii_low_speed     = mii_q[`SGCR_BIT_LOW_SPEED];
    ctrl.null_vlan_id_substitute = mii_q[`SGCR_BIT_NULL_VID];
    ctrl.led_mode_sel_hi         = led_q[`SGCR_BIT_LED_HI];
    ctrl.led_mode_sel_lo         = led_q[`SGCR_BIT_LED_LO];
    ctrl.storm_threshold         = {mii_q[2:0], storm_lo_q};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port 3 speed comes from our own register; ports 1..n-1 from the PHYs
  logic [NPORT-1:0] speed_sel;
  logic [NPORT-1:0] drop_w;

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      if (gp == NPORT - 1) begin : g_mii
        assign speed_sel[gp] = mii_q[`SGCR_BIT_LOW_SPEED];
      end else begin : g_phy
        assign speed_sel[gp] = port_low_speed[gp];
      end
      sgcr_storm_meter #(
        .FAST_CYC (FAST_CYC),
        .SLOW_CYC (SLOW_CYC)
      ) i_sgcr_storm_meter (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .low_speed   (speed_sel[gp]),
        .threshold   ({mii_q[2:0], storm_lo_q}),
        .bcast_block (bcast_block[gp]),
        .drop        (drop_w[gp])
      );
    end
  endgenerate

  assign storm_drop = drop_w;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_boot_straps: assert property (
    state_q == SGCR_ST_BOOT |=> (mii_q[`SGCR_BIT_FLOW] ==
      $past(strap_s2_q.sw_mii_rx_bit3_strap) && led_q[`SGCR_BIT_LED_HI] ==
      $past(strap_s2_q.led_mode_sel_hi)))
    else $error("strap not captured at boot");

  a_boot_speed: assert property (
    state_q == SGCR_ST_BOOT |=> ctrl.port3_mii_low_speed ==
      $past(strap_s2_q.sw_mii_rx_bit1_strap))
    else $error("speed strap not captured");

  a_flow_write: assert property (
    (state_q == SGCR_ST_RUN && reg_wr && reg_addr == `SGCR_OFS_MII_STORM)
      |=> ctrl.flow_ctrl_en == $past(reg_wdata[`SGCR_BIT_FLOW]))
    else $error("flow enable not written");

  a_null_vid_write: assert property (
    (state_q == SGCR_ST_RUN && reg_wr && reg_addr == `SGCR_OFS_MII_STORM)
      |=> ctrl.null_vlan_id_substitute == $past(reg_wdata[3]))
    else $error("null vid bit not written");

  a_threshold_join: assert property (
    (state_q == SGCR_ST_RUN && reg_wr && reg_addr == `SGCR_OFS_STORM_LO)
      |=> ctrl.storm_threshold[7:0] == $past(reg_wdata)
        && $stable(ctrl.storm_threshold[10:8]))
    else $error("threshold low byte not written");

  a_led_lo_write: assert property (
    (state_q == SGCR_ST_RUN && reg_wr && reg_addr == `SGCR_OFS_LED_CTRL)
      |=> ctrl.led_mode_sel_lo == $past(reg_wdata[1])
        && ctrl.led_mode_sel_hi == $past(reg_wdata[7]))
    else $error("led select not written");

  a_test_hold: assert property (
    !(reg_wr && reg_addr == `SGCR_OFS_TEST_B) |=> $stable(test_b_q)
      || $past(state_q == SGCR_ST_BOOT))
    else $error("test register changed unwritten");

  a_read_unmapped: assert property (
    (reg_rd && (reg_addr < `SGCR_OFS_MII_STORM
      || reg_addr > `SGCR_OFS_LED_CTRL)) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_read_test_c: assert property (
    (reg_rd && reg_addr == `SGCR_OFS_TEST_C) |=> reg_rdata == $past(test_c_q))
    else $error("test c read wrong");

  a_boot_led_lo: assert property (
    state_q == SGCR_ST_BOOT |=> led_q[`SGCR_BIT_LED_LO] ==
      $past(strap_s2_q.led_mode_sel_lo))
    else $error("led low strap not captured");

  a_boot_leaves: assert property (
    state_q == SGCR_ST_BOOT |=> state_q == SGCR_ST_RUN)
    else $error("boot state not left");

  a_speed_write: assert property (
    (state_q == SGCR_ST_RUN && reg_wr && reg_addr == `SGCR_OFS_MII_STORM)
      |=> ctrl.port3_mii_low_speed == $past(reg_wdata[`SGCR_BIT_LOW_SPEED]))
    else $error("speed bit not written");

  a_storm_hi_write: assert property (
    (state_q == SGCR_ST_RUN && reg_wr && reg_addr == `SGCR_OFS_MII_STORM)
      |=> ctrl.storm_threshold[10:8] == $past(reg_wdata[2:0]))
    else $error("threshold high bits not written");

  a_read_mii: assert property (
    (reg_rd && reg_addr == `SGCR_OFS_MII_STORM)
      |=> reg_rdata == $past(mii_q))
    else $error("mii register read wrong");

endmodule : sgcr_regs

// ---- logic/sgcr_storm_meter.sv ----
// Per-port broadcast storm meter with its own measurement period
`timescale 1ns/100ps
`include "sgcr_cfg.svh"

module sgcr_storm_meter #(
  parameter int unsigned FAST_CYC = `SGCR_PERIOD_FAST_CYC,
  parameter int unsigned SLOW_CYC = `SGCR_PERIOD_SLOW_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        low_speed,
  input  wire logic [10:0] threshold,
  input  wire logic        bcast_block,
  output logic             drop
);
  import sgcr_pkg::*;

  localparam logic [`SGCR_PERIOD_W-1:0] FAST_LAST =
    `SGCR_PERIOD_W'(FAST_CYC - 1);
  localparam logic [`SGCR_PERIOD_W-1:0] SLOW_LAST =
    `SGCR_PERIOD_W'(SLOW_CYC - 1);

  logic [`SGCR_PERIOD_W-1:0] tick_q, tick_d;
  logic [11:0]               count_q, count_d;
  logic                      drop_q, drop_d;
  logic                      period_end;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    period_end = (tick_q >= (low_speed ? SLOW_LAST : FAST_LAST));
    tick_d     = period_end ? '0 : tick_q + 1'b1;
    count_d    = count_q;
    drop_d     = drop_q;
    if (period_end) begin
      // New period starts clean; a block in the boundary cycle counts anew
      count_d = {11'h000, bcast_block};
      drop_d  = 1'b0;
    end else begin
      if (bcast_block && count_q != 12'hfff) begin
        count_d = count_q + 12'h001;
      end
      // Saturating count; a zero threshold drops all but the cycle after each period end
      if (count_d >= {1'b0, threshold}) begin
        drop_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_q  <= '0;
      count_q <= 12'h000;
      drop_q  <= 1'b0;
    end else begin
      tick_q  <= tick_d;
      count_q <= count_d;
      drop_q  <= drop_d;
    end
  end

  assign drop = drop_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_drop_on_reach: assert property (
    (!period_end && count_d >= {1'b0, threshold}) |=> drop_q)
    else $error("drop not raised at threshold");

  a_period_clears: assert property (
    period_end |=> (!drop_q && tick_q == '0))
    else $error("period end did not clear meter");

  a_tick_bounded: assert property (
    tick_q <= (low_speed ? SLOW_LAST : FAST_LAST) || $changed(low_speed)
      || $past(low_speed))
    else $error("period timer overran");

endmodule : sgcr_storm_meter
